// ===== hls_regs.svh
`ifndef HLS_REGS_SVH
`define HLS_REGS_SVH
// apb register map, byte addresses
`define HLS_CTRL_OFS    12'h000
`define HLS_STAT_OFS    12'h004
// control field: selected head
`define HLS_CTRL_HEAD_LSB 0
`define HLS_CTRL_HEAD_W   4
`define HLS_CTRL_RST      4'h0
// status fields
`define HLS_STAT_STATE_LSB 0
`define HLS_STAT_TRACK_LSB 8
`define HLS_STAT_XFER_BIT  16
`define HLS_STAT_HLSW_BIT  17
// geometry
`define HLS_HEAD_MAX    4'h9
`define HLS_TRACK_MAX   8'hC7
// pack speed threshold in rpm
`define HLS_RPM_MIN     12'd1900
// carriage speeds in ips
`define HLS_IPS_FAST    4'h6
`define HLS_IPS_SLOW    4'h2
// timing: clock rate, tick length, delays in ms
`define HLS_CLK_MHZ     200
`define HLS_TICK_US     1000
`define HLS_TICK_CYC    (`HLS_TICK_US * `HLS_CLK_MHZ)
`define HLS_PURGE_MS    52000
`define HLS_PAWL_MS     20
`endif

// ===== hls_pkg.sv
package hls_pkg;
  // sequencer states, one-hot
  typedef enum logic [7:0] {
    ST_WAIT   = 8'h01,
    ST_PURGE  = 8'h02,
    ST_PULL   = 8'h04,
    ST_LOAD   = 8'h08,
    ST_RETR   = 8'h10,
    ST_CREEP  = 8'h20,
    ST_READY  = 8'h40,
    ST_UNLOAD = 8'h80
  } hls_state_t;
endpackage

// ===== hls_first_seek.sv
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "hls_regs.svh"
module hls_first_seek #(
  parameter int TICK_CYC = `HLS_TICK_CYC,
  parameter int PURGE_MS = `HLS_PURGE_MS,
  parameter int PAWL_MS  = `HLS_PAWL_MS
) (
  // clock, reset, enable
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        CE,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // drive sensors
  input  wire logic        PWR_OK,
  input  wire logic [11:0] PACK_RPM,
  input  wire logic        HL_SWITCH,
  input  wire logic        HOME_CELL,
  input  wire logic        TRACK_PULSE,
  // actuators
  output logic             DETENT_SOL,
  output logic             CAM_LATCH_SOL,
  output logic             HL_LATCH_SOL,
  output logic             MOTOR_FWD,
  output logic             MOTOR_REV,
  output logic      [3:0]  MOTOR_IPS,
  // controller side
  output logic             XFER_EN,
  output logic      [3:0]  HEAD_SEL,
  output logic      [7:0]  TRACK
);

  hls_pkg::hls_state_t state_r;
  hls_pkg::hls_state_t state_nxt;
  logic [17:0] tick_cnt_r;
  logic [15:0] ms_cnt_r;
  logic [3:0]  head_r;

  // condition decode
  wire speed_ok = (PACK_RPM >= `HLS_RPM_MIN);
  wire lost     = !PWR_OK || !speed_ok;
  wire tick     = (tick_cnt_r == 18'(TICK_CYC - 1));
  wire st_chg   = (state_nxt != state_r);
  wire purge_dn = tick && (ms_cnt_r == 16'(PURGE_MS - 1));
  wire pawl_dn  = tick && (ms_cnt_r == 16'(PAWL_MS - 1));

  // slow tick and millisecond timer, restart on every state change
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tick_cnt_r <= 18'h00000;
      ms_cnt_r   <= 16'h0000;
    end else if (CE) begin
      tick_cnt_r <= (st_chg || tick) ? 18'h00000 : tick_cnt_r + 18'h00001;
      if (st_chg)
        ms_cnt_r <= 16'h0000;
      else if (tick)
        ms_cnt_r <= ms_cnt_r + 16'h0001;
    end
  end

  // sequencer next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      hls_pkg::ST_WAIT: begin
        if (!lost)
          state_nxt = hls_pkg::ST_PURGE;
      end
      hls_pkg::ST_PURGE: begin
        if (lost)
          state_nxt = hls_pkg::ST_WAIT;
        else if (purge_dn)
          state_nxt = hls_pkg::ST_PULL;
      end
      hls_pkg::ST_PULL: begin
        if (lost)
          state_nxt = hls_pkg::ST_UNLOAD;
        else if (pawl_dn)
          state_nxt = hls_pkg::ST_LOAD;
      end
      hls_pkg::ST_LOAD: begin
        if (lost)
          state_nxt = hls_pkg::ST_UNLOAD;
        else if (HL_SWITCH)
          state_nxt = hls_pkg::ST_RETR;
      end
      hls_pkg::ST_RETR: begin
        if (lost)
          state_nxt = hls_pkg::ST_UNLOAD;
        else if (HOME_CELL)
          state_nxt = hls_pkg::ST_CREEP;
      end
      hls_pkg::ST_CREEP: begin
        // home low means data area, cylinder 00
        if (lost)
          state_nxt = hls_pkg::ST_UNLOAD;
        else if (!HOME_CELL)
          state_nxt = hls_pkg::ST_READY;
      end
      hls_pkg::ST_READY: begin
        if (lost)
          state_nxt = hls_pkg::ST_UNLOAD;
      end
      hls_pkg::ST_UNLOAD: begin
        // clear of the pack once the home cell sees light
        if (HOME_CELL)
          state_nxt = hls_pkg::ST_WAIT;
      end
      default: state_nxt = hls_pkg::ST_WAIT;
    endcase
  end

  // actuator decode from the next state, so outputs come from flops
  wire n_pull  = (state_nxt == hls_pkg::ST_PULL);
  wire n_load  = (state_nxt == hls_pkg::ST_LOAD);
  wire n_retr  = (state_nxt == hls_pkg::ST_RETR);
  wire n_creep = (state_nxt == hls_pkg::ST_CREEP);
  wire n_ready = (state_nxt == hls_pkg::ST_READY);
  wire n_unld  = (state_nxt == hls_pkg::ST_UNLOAD);
  wire n_det   = n_pull || n_load || n_retr || n_creep || n_unld;
  wire n_fwd   = n_load || n_creep;
  wire n_rev   = n_retr || n_unld;
  wire n_hl    = !lost && (n_load || n_retr || n_creep || n_ready);
  wire [3:0] n_ips = (n_load || n_rev) ? `HLS_IPS_FAST
                   : n_creep ? `HLS_IPS_SLOW : 4'h0;

  // track counting, saturating at both ends
  wire moving   = MOTOR_FWD || MOTOR_REV;
  wire trk_up   = TRACK_PULSE && MOTOR_FWD && (TRACK != `HLS_TRACK_MAX);
  wire trk_dn   = TRACK_PULSE && MOTOR_REV && (TRACK != 8'h00);
  wire trk_zero = (state_r == hls_pkg::ST_CREEP) && n_ready;

  // state, actuators, track
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r       <= hls_pkg::ST_WAIT;
      DETENT_SOL    <= 1'b0;
      CAM_LATCH_SOL <= 1'b0;
      HL_LATCH_SOL  <= 1'b0;
      MOTOR_FWD     <= 1'b0;
      MOTOR_REV     <= 1'b0;
      MOTOR_IPS     <= 4'h0;
      XFER_EN       <= 1'b0;
      TRACK         <= 8'h00;
    end else if (CE) begin
      state_r       <= state_nxt;
      DETENT_SOL    <= n_det;
      CAM_LATCH_SOL <= n_load;
      HL_LATCH_SOL  <= n_hl;
      MOTOR_FWD     <= n_fwd;
      MOTOR_REV     <= n_rev;
      MOTOR_IPS     <= n_ips;
      XFER_EN       <= n_ready;
      if (trk_zero)
        TRACK <= 8'h00;
      else if (moving && trk_up)
        TRACK <= TRACK + 8'h01;
      else if (moving && trk_dn)
        TRACK <= TRACK - 8'h01;
    end
  end

  // apb decode; answer is registered in setup, zero wait states
  wire setup   = PSEL && !PENABLE;
  wire acc     = PSEL && PENABLE && PREADY;
  wire hit_c   = (PADDR == `HLS_CTRL_OFS);
  wire hit_s   = (PADDR == `HLS_STAT_OFS);
  wire [3:0] wr_head = PWDATA[`HLS_CTRL_HEAD_LSB +: `HLS_CTRL_HEAD_W];
  wire bad_hd  = hit_c && PWRITE && (wr_head > `HLS_HEAD_MAX);
  // status is read-only; unmapped and bad writes are refused
  wire err     = !(hit_c || hit_s) || (hit_s && PWRITE) || bad_hd;
  wire [31:0] ctrl_rd = {28'h0000000, head_r};
  wire [31:0] stat_rd = {14'h0000, HL_SWITCH, XFER_EN, TRACK,
                         state_r};
  wire [31:0] rd_mux  = hit_c ? ctrl_rd : hit_s ? stat_rd : 32'h00000000;

  // apb answer and control register
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      PREADY   <= 1'b0;
      PSLVERR  <= 1'b0;
      PRDATA   <= 32'h00000000;
      head_r   <= `HLS_CTRL_RST;
      HEAD_SEL <= `HLS_CTRL_RST;
    end else if (CE) begin
      PREADY   <= setup;
      PSLVERR  <= setup && err;
      PRDATA   <= (setup && !PWRITE) ? rd_mux : 32'h00000000;
      if (acc && PWRITE && hit_c && !PSLVERR)
        head_r <= wr_head;
      HEAD_SEL <= head_r;
    end
  end

  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N || !CE);

  sequence s_purge_end;
    state_r == hls_pkg::ST_PURGE && purge_dn && !lost;
  endsequence
  sequence s_loaded_sw;
    state_r == hls_pkg::ST_LOAD && HL_SWITCH && !lost;
  endsequence

  property p_wait_speed;
    state_r == hls_pkg::ST_WAIT && lost |=> state_r == hls_pkg::ST_WAIT;
  endproperty
  a_wait_speed: assert property (p_wait_speed)
    else $error("left wait without pack speed");

  property p_pull_from_purge;
    $rose(state_r == hls_pkg::ST_PULL) |->
      $past(state_r == hls_pkg::ST_PURGE && purge_dn);
  endproperty
  a_pull_from_purge: assert property (p_pull_from_purge)
    else $error("loading began before purge ended");

  property p_auto_start;
    s_purge_end |=> DETENT_SOL && state_r == hls_pkg::ST_PULL;
  endproperty
  a_auto_start: assert property (p_auto_start)
    else $error("seek did not start after purge");

  property p_pawl_first;
    $rose(MOTOR_FWD) && MOTOR_IPS == `HLS_IPS_FAST |->
      $past(DETENT_SOL, 1) && $past(DETENT_SOL, 2);
  endproperty
  a_pawl_first: assert property (p_pawl_first)
    else $error("carriage moved before pawl pulled");

  property p_cam_fwd;
    MOTOR_FWD && MOTOR_IPS == `HLS_IPS_FAST |-> CAM_LATCH_SOL;
  endproperty
  a_cam_fwd: assert property (p_cam_fwd)
    else $error("cam latch off during loading advance");

  property p_latch_speed;
    HL_LATCH_SOL |-> $past(speed_ok && PWR_OK);
  endproperty
  a_latch_speed: assert property (p_latch_speed)
    else $error("latch solenoid on without pack speed");

  property p_cam_release;
    s_loaded_sw |=> !CAM_LATCH_SOL ##0 MOTOR_REV;
  endproperty
  a_cam_release: assert property (p_cam_release)
    else $error("cam latch held after heads loaded");

  property p_unload;
    lost && state_r != hls_pkg::ST_WAIT &&
      state_r != hls_pkg::ST_PURGE &&
      !(state_r == hls_pkg::ST_UNLOAD && HOME_CELL) |=>
      !HL_LATCH_SOL && !XFER_EN && MOTOR_REV;
  endproperty
  a_unload: assert property (p_unload)
    else $error("heads not unloaded on power or speed loss");

  property p_retract;
    state_r == hls_pkg::ST_RETR |->
      MOTOR_REV && MOTOR_IPS == `HLS_IPS_FAST;
  endproperty
  a_retract: assert property (p_retract)
    else $error("retract not at fast reverse");

  property p_cyl_zero;
    state_r == hls_pkg::ST_CREEP && !HOME_CELL && !lost |=>
      !DETENT_SOL && TRACK == 8'h00 && XFER_EN;
  endproperty
  a_cyl_zero: assert property (p_cyl_zero)
    else $error("pawl not dropped at cylinder 00");

  property p_xfer_loaded;
    XFER_EN |-> HL_LATCH_SOL && state_r == hls_pkg::ST_READY;
  endproperty
  a_xfer_loaded: assert property (p_xfer_loaded)
    else $error("transfer enabled with heads unloaded");

  property p_head_range;
    HEAD_SEL <= `HLS_HEAD_MAX;
  endproperty
  a_head_range: assert property (p_head_range)
    else $error("head select beyond 09");

  property p_track_range;
    TRACK <= `HLS_TRACK_MAX;
  endproperty
  a_track_range: assert property (p_track_range)
    else $error("track beyond 199");

  // unload keeps backing out until the home cell sees light
  property p_unld_clear;
    state_r == hls_pkg::ST_UNLOAD && !HOME_CELL |=>
      state_r == hls_pkg::ST_UNLOAD && MOTOR_REV && !HL_LATCH_SOL;
  endproperty
  a_unld_clear: assert property (p_unld_clear)
    else $error("carriage not driven clear on unload");

  property p_home_creep;
    state_r == hls_pkg::ST_RETR && HOME_CELL && !lost |=>
      MOTOR_FWD && MOTOR_IPS == `HLS_IPS_SLOW;
  endproperty
  a_home_creep: assert property (p_home_creep)
    else $error("no slow forward creep after home seen");

  // latch must hold for every loaded state while speed and power hold
  property p_latch_loaded;
    (state_r == hls_pkg::ST_RETR || state_r == hls_pkg::ST_CREEP ||
      state_r == hls_pkg::ST_READY) && !lost |=> HL_LATCH_SOL;
  endproperty
  a_latch_loaded: assert property (p_latch_loaded)
    else $error("latch solenoid dropped while loaded");

  property p_fwd_raises;
    MOTOR_FWD && TRACK_PULSE && TRACK != `HLS_TRACK_MAX &&
      state_r != hls_pkg::ST_CREEP |=> TRACK == $past(TRACK) + 8'h01;
  endproperty
  a_fwd_raises: assert property (p_fwd_raises)
    else $error("forward track pulse did not raise track");

  property p_purge_abort;
    state_r == hls_pkg::ST_PURGE && lost |=>
      state_r == hls_pkg::ST_WAIT && ms_cnt_r == 16'h0000;
  endproperty
  a_purge_abort: assert property (p_purge_abort)
    else $error("purge not abandoned on speed loss");

endmodule // hls_first_seek

// ===== hls_carriage.sv
`timescale 1ns/1ps
// carriage, cam and latch mechanics as seen by the sequencer
module hls_carriage (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // motor and solenoid commands
  input  wire logic fwd,
  input  wire logic rev,
  input  wire logic cam,
  input  wire logic latch,
  // sensors
  output logic      hl_sw,
  output logic      home,
  output logic      pulse
);
  logic [4:0] pos_r;
  logic [1:0] div_r;
  logic       step;
  // one step per four clocks, slow enough to see each state
  assign step = (fwd ^ rev) && div_r == 2'h3;
  // cell lit outside the data area, position 8 is cylinder 00
  assign home = pos_r < 5'h08;
  // position, track pulses and the loaded switch
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_r <= 5'h00;
      div_r <= 2'h0;
      hl_sw <= 1'b0;
      pulse <= 1'b0;
    end else begin
      div_r <= div_r + 2'h1;
      pulse <= step && (fwd ? pos_r >= 5'h08 : pos_r > 5'h08);
      if (step && fwd)
        pos_r <= pos_r + 5'h01;
      if (step && rev && pos_r != 5'h00)
        pos_r <= pos_r - 5'h01;
      // arm catches only while cam held and latch enabled
      if (!latch)
        hl_sw <= 1'b0;
      else if (cam && pos_r >= 5'h0C)
        hl_sw <= 1'b1;
    end
  end
endmodule // hls_carriage

// ===== head_load_first_seek_sequencer_bench.sv
`timescale 1ns/1ps
module head_load_first_seek_sequencer_bench;
  localparam int TK = 4;
  localparam int PM = 5;
  localparam int PW = 2;
  logic        clk, rst_n, psel, penable, pwrite, pwr_ok;
  logic [11:0] paddr, rpm;
  logic [31:0] pwdata, prdata, hr;
  logic        pready, pslverr, hl_sw, home, pulse;
  logic        det, cam, hl, fwd, rev, xfer, ce;
  logic [3:0]  ips, head;
  logic [7:0]  track;
  logic [32:0] exp_q[$];
  int          error_cnt, checks, n;
  hls_first_seek #(.TICK_CYC(TK), .PURGE_MS(PM), .PAWL_MS(PW)) u_dut (
    .CLK(clk), .RST_N(rst_n), .CE(ce), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .PWR_OK(pwr_ok), .PACK_RPM(rpm),
    .HL_SWITCH(hl_sw), .HOME_CELL(home), .TRACK_PULSE(pulse),
    .DETENT_SOL(det), .CAM_LATCH_SOL(cam), .HL_LATCH_SOL(hl),
    .MOTOR_FWD(fwd), .MOTOR_REV(rev), .MOTOR_IPS(ips), .XFER_EN(xfer),
    .HEAD_SEL(head), .TRACK(track));
  hls_carriage u_cart (.clk(clk), .rst_n(rst_n), .fwd(fwd), .rev(rev),
    .cam(cam), .latch(hl), .hl_sw(hl_sw), .home(home), .pulse(pulse));
  // 200 MHz
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic check(input string nm, input logic [32:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // actuators packed: pawl, cam, latch, fwd, rev, speed, transfer
  function automatic logic [32:0] act();
    return {23'h0, det, cam, hl, fwd, rev, ips, xfer};
  endfunction
  function automatic logic [32:0] ea(logic [4:0] s, logic [3:0] i, logic x);
    return {23'h0, s, i, x};
  endfunction
  // one apb transfer, answer noted as {error, read data}
  task automatic apb(input logic [11:0] a, input logic w,
                     input logic [31:0] d, input logic [32:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // wait states are the slave's business; the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // bounded wait, the count of cycles waited is returned
  task automatic wait_for(ref logic s, input logic v, output int c);
    c = 0;
    while (s !== v && c < 400) begin
      @(posedge clk);
      c++;
    end
    check("wait", {32'h0, s}, {32'h0, v});
  endtask
  // answered transfers against the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1) begin
      if (exp_q.size() == 0)
        check("apb_extra", 33'h0, 33'h1);
      else
        check("apb", {pslverr, prdata}, exp_q.pop_front());
    end
  end
  // hang guard, whole run is well under a thousand cycles
  initial begin
    repeat (4000) @(posedge clk);
    error_cnt++;
    $display("[ERR] watchdog exp done seen hang");
    stop_test();
  end
  initial begin
    error_cnt = 0;
    checks = 0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pwr_ok = 1'b1;
    ce = 1'b1;
    rpm = 12'h000;
    void'($urandom(13));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rpm <= 12'($urandom_range(1899, 0));
    check("reset", act(), 33'h0);
    apb(12'h004, 1'b0, 32'h0, 33'h1);
    apb(12'h000, 1'b0, 32'h0, 33'h0);
    // every head code, codes above nine refused
    for (int h = 0; h < 16; h++)
      apb(12'h000, 1'b1, 32'(h), {h > 9, 32'h0});
    hr = 32'($urandom_range(9, 0));
    apb(12'h000, 1'b1, hr, 33'h0);
    apb(12'h000, 1'b0, 32'h0, {1'b0, hr});
    check("head", head, hr);
    apb(12'h004, 1'b1, 32'h0, {1'b1, 32'h0});
    apb(12'h008, 1'b1, $urandom, {1'b1, 32'h0});
    // speed lost mid purge, timer must start over
    rpm <= 12'h76C;
    repeat (10) @(posedge clk);
    rpm <= 12'($urandom_range(1899, 0));
    repeat (30) @(posedge clk);
    check("purge_abort", act(), 33'h0);
    apb(12'h004, 1'b0, 32'h0, 33'h1);
    rpm <= 12'h76C;
    wait_for(det, 1'b1, n);
    check("purge_len", n >= TK * PM && n <= TK * PM + 2, 33'h1);
    check("pull", act(), ea(5'b10000, 4'h0, 1'b0));
    wait_for(fwd, 1'b1, n);
    check("pawl_len", n >= TK * PW && n <= TK * PW + 2, 33'h1);
    check("load", act(), ea(5'b11110, 4'h6, 1'b0));
    wait_for(rev, 1'b1, n);
    check("retract", act(), ea(5'b10101, 4'h6, 1'b0));
    check("track", track, 33'h4);
    wait_for(fwd, 1'b1, n);
    check("creep", act(), ea(5'b10110, 4'h2, 1'b0));
    wait_for(xfer, 1'b1, n);
    check("ready", act(), ea(5'b00100, 4'h0, 1'b1));
    check("cyl00", track, 33'h0);
    apb(12'h004, 1'b0, 32'h0, 33'h0_0003_0040);
    // speed loss with heads loaded
    rpm <= 12'($urandom_range(1899, 0));
    wait_for(hl, 1'b0, n);
    check("unload", act(), ea(5'b10001, 4'h6, 1'b0));
    wait_for(det, 1'b0, n);
    apb(12'h004, 1'b0, 32'h0, 33'h1);
    // spin up again; enable low 30 cycles after 5 running purge cycles
    rpm <= 12'h76C;
    repeat (5) @(posedge clk);
    ce <= 1'b0;
    repeat (30) @(posedge clk);
    ce <= 1'b1;
    wait_for(det, 1'b1, n);
    check("ce_hold", n >= TK * PM - 5 && n <= TK * PM - 3, 33'h1);
    // power lost while the carriage advances
    wait_for(fwd, 1'b1, n);
    pwr_ok <= 1'b0;
    wait_for(hl, 1'b0, n);
    check("pwr_loss", act(), ea(5'b10001, 4'h6, 1'b0));
    wait_for(det, 1'b0, n);
    check("off", act(), 33'h0);
    repeat (2) @(posedge clk);
    check("notes", exp_q.size(), 33'h0);
    stop_test();
  end
endmodule // head_load_first_seek_sequencer_bench
